// file: common/fuel_gauge_buck_defs.svh
// register offsets, reset values and field constants of the gauge and step-down bank
// assumes inclusion from packages or modules that need the bank's constants
`ifndef FUEL_GAUGE_BUCK_DEFS_SVH
`define FUEL_GAUGE_BUCK_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define ADDR_ACCUM_HIGH 8'h23
`define ADDR_ACCUM_LOW 8'h24
`define ADDR_VOLTAGE_HIGH 8'h25
`define ADDR_VOLTAGE_LOW 8'h26
`define ADDR_GAUGE_MODE 8'h27
`define ADDR_REFRESH 8'h28
`define ADDR_STEPDOWN_CFG 8'h29
`define ADDR_STEPDOWN_VOUT 8'h2A

// ****************************************
// field positions and widths
// ****************************************
`define REFRESH_BIT 7
`define ACCUM_WIDTH 12
`define VOLTAGE_WIDTH 13
`define LEVEL_WIDTH 7
`define ACCUM_LOW_PAD 4'h0
`define VOLTAGE_LOW_PAD 3'h0
`define REFRESH_READ 8'h00
`define UNMAPPED_READ 8'h00

// ****************************************
// reset values
// ****************************************
`define GAUGE_MODE_RESET 8'h50
`define PEAK_LIMIT_RESET 2'h3
`define PULSE_STOP_RESET 1'h0
`define SWITCH_DELAY_RESET 2'h0
`define ACCUM_RESET 12'h000
`define VOLTAGE_RESET 13'h0000
`define LEVEL_RESET 7'h00
`define CAPACITY_RESET 8'h00

// ****************************************
// aging reduction shifts, 0.8 / 1.6 / 3.1 / 6.3 percent
// ****************************************
`define AGE_SHIFT_00 3'd7
`define AGE_SHIFT_01 3'd6
`define AGE_SHIFT_10 3'd5
`define AGE_SHIFT_11 3'd4

`endif

// file: common/fuel_gauge_buck_pkg.sv
// types shared by the gauge and step-down register bank
// assumes the defs header sits on the include path
package fuel_gauge_buck_pkg;
   // gauge operation control layout, msb first
   typedef struct packed {
      logic [1:0] low_charge_threshold;
      logic [1:0] sleep_current_threshold;
      logic [1:0] sleep_update_interval;
      logic gauge_sleep_select;
      logic gauge_enable;
   } gauge_mode_s;
   // step-down configuration layout
   typedef struct packed {
      logic [1:0] soft_start;
      logic [1:0] stepdown_peak_limit;
      logic forced_pulse_width_modulation;
      logic stepdown_pulse_stop;
      logic stepdown_output_discharge;
      logic stepdown_enable;
   } stepdown_cfg_s;
   // step-down output voltage layout
   typedef struct packed {
      logic [1:0] stepdown_switch_delay;
      logic [5:0] stepdown_voltage_code;
   } stepdown_vout_s;
   // refresh sequence tracker
   typedef enum logic [1:0] {
      REFRESH_IDLE = 2'b01,
      REFRESH_ARMED = 2'b10
   } refresh_state_e;
endpackage : fuel_gauge_buck_pkg

// file: hdl/refresh_sequencer.sv
// detects the write-one-then-write-zero sequence on the refresh bit
// assumes one write strobe per host write, synchronous to clk
`timescale 1ns/10ps
module refresh_sequencer (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // refresh register write
   input wire logic wr_strobe,
   input wire logic wr_bit,
   // one-cycle refresh request
   output logic refresh_pulse_reg
);
   import fuel_gauge_buck_pkg::*;
   refresh_state_e state_reg;

   // ****************************************
   // sequence tracking
   // ****************************************
   // a second one while armed keeps it armed; only a zero completes it
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= REFRESH_IDLE;
      end else if (wr_strobe) begin
         unique case (state_reg)
            REFRESH_IDLE: begin
               if (wr_bit) state_reg <= REFRESH_ARMED;
            end
            REFRESH_ARMED: begin
               if (!wr_bit) state_reg <= REFRESH_IDLE;
            end
            default: state_reg <= REFRESH_IDLE;
         endcase
      end
   end

   // pulse when the zero follows the one
   always_ff @(posedge clk) begin
      if (rst) refresh_pulse_reg <= 1'b0;
      else refresh_pulse_reg <= wr_strobe && !wr_bit && (state_reg == REFRESH_ARMED);
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_armed_zero;
      wr_strobe && !wr_bit && state_reg == REFRESH_ARMED;
   endsequence
   a_refresh_fires: assert property (s_armed_zero |=> refresh_pulse_reg)
      else $error("refresh did not fire after one then zero");
   a_refresh_cause: assert property (refresh_pulse_reg |-> $past(state_reg == REFRESH_ARMED))
      else $error("refresh fired without arming");
endmodule : refresh_sequencer

// file: hdl/charge_accumulator.sv
// 12-bit charge accumulation count with aging capacity reduction on wrap
// assumes charge_step is a one-cycle pulse from the gauge core
`timescale 1ns/10ps
`include "fuel_gauge_buck_defs.svh"
module charge_accumulator (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // gauge core events and settings
   input wire logic charge_step,
   input wire logic aging_enable,
   input wire logic [1:0] aging_code,
   input wire logic cap_load,
   input wire logic [7:0] cap_setting,
   // state
   output logic [11:0] count_reg,
   output logic [7:0] capacity_reg,
   output logic overflow_reg
);
   logic wrap;
   logic [2:0] shift;
   assign wrap = charge_step && (count_reg == {`ACCUM_WIDTH{1'b1}});
   // shift approximates the percentage: 1/128, 1/64, 1/32, 1/16
   always_comb begin
      unique case (aging_code)
         2'b00: shift = `AGE_SHIFT_00;
         2'b01: shift = `AGE_SHIFT_01;
         2'b10: shift = `AGE_SHIFT_10;
         default: shift = `AGE_SHIFT_11;
      endcase
   end

   // ****************************************
   // count and capacity
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) count_reg <= `ACCUM_RESET;
      else if (charge_step) count_reg <= count_reg + 12'h001;
   end

   // a fresh capacity setting wins over a reduction in the same cycle
   always_ff @(posedge clk) begin
      if (rst) capacity_reg <= `CAPACITY_RESET;
      else if (cap_load) capacity_reg <= cap_setting;
      else if (wrap && aging_enable) capacity_reg <= capacity_reg - (capacity_reg >> shift);
   end

   always_ff @(posedge clk) begin
      if (rst) overflow_reg <= 1'b0;
      else overflow_reg <= wrap;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_age_reduce: assert property (wrap && aging_enable && !cap_load |=>
      capacity_reg == $past(capacity_reg) - ($past(capacity_reg) >> $past(shift)))
      else $error("capacity not reduced on overflow");
   a_age_hold: assert property (wrap && !aging_enable && !cap_load |=> $stable(capacity_reg))
      else $error("capacity changed with aging disabled");
endmodule : charge_accumulator

// file: hdl/fuel_gauge_buck_ctrl_regs.sv
// register bank for gauge readback, gauge control and step-down regulator settings
// assumes a host register port synchronous to clk; gauge core gives pulses and levels
`timescale 1ns/10ps
`include "fuel_gauge_buck_defs.svh"
module fuel_gauge_buck_ctrl_regs #(
   parameter logic [1:0] SOFT_START_DEFAULT = 2'h0,
   parameter logic FORCED_PULSE_WIDTH_MODULATION_DEFAULT = 1'b0,
   parameter logic DISCHARGE_DEFAULT = 1'b0,
   parameter logic OUTPUT_ON_DEFAULT = 1'b0,
   parameter logic [5:0] VOLTAGE_CODE_DEFAULT = 6'h00
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wr_data,
   input wire logic reg_rd_en,
   output logic [7:0] reg_rd_data_reg,
   output logic reg_rd_valid_reg,
   // gauge core measurements and events
   input wire logic [12:0] vbat_measured,
   input wire logic [6:0] charge_level_measured,
   input wire logic gauge_update,
   input wire logic charge_step,
   input wire logic aging_enable,
   input wire logic [1:0] aging_code,
   input wire logic cap_load,
   input wire logic [7:0] cap_setting,
   // gauge controls and readback state
   output fuel_gauge_buck_pkg::gauge_mode_s gauge_mode_reg,
   output logic [6:0] charge_level_reg,
   output logic [7:0] capacity_reg,
   output logic accum_overflow_reg,
   // step-down regulator controls
   output fuel_gauge_buck_pkg::stepdown_cfg_s stepdown_cfg_reg,
   output fuel_gauge_buck_pkg::stepdown_vout_s stepdown_vout_reg
);
   import fuel_gauge_buck_pkg::*;

   // ****************************************
   // write decode
   // ****************************************
   logic wr_mode;
   logic wr_refresh;
   logic wr_cfg;
   logic wr_vout;
   assign wr_mode = reg_wr_en && (reg_addr == `ADDR_GAUGE_MODE);
   assign wr_refresh = reg_wr_en && (reg_addr == `ADDR_REFRESH);
   assign wr_cfg = reg_wr_en && (reg_addr == `ADDR_STEPDOWN_CFG);
   assign wr_vout = reg_wr_en && (reg_addr == `ADDR_STEPDOWN_VOUT);

   // ****************************************
   // refresh sequence and accumulator
   // ****************************************
   logic refresh_pulse;
   logic [11:0] accum_live;
   logic snapshot;

   refresh_sequencer u_refresh (
      .clk(clk),
      .rst(rst),
      .wr_strobe(wr_refresh),
      .wr_bit(reg_wr_data[`REFRESH_BIT]),
      .refresh_pulse_reg(refresh_pulse)
   );

   charge_accumulator u_accum (
      .clk(clk),
      .rst(rst),
      .charge_step(charge_step),
      .aging_enable(aging_enable),
      .aging_code(aging_code),
      .cap_load(cap_load),
      .cap_setting(cap_setting),
      .count_reg(accum_live),
      .capacity_reg(capacity_reg),
      .overflow_reg(accum_overflow_reg)
   );

   // gauge updates only count while the gauge is enabled; a refresh always counts
   assign snapshot = refresh_pulse || (gauge_update && gauge_mode_reg.gauge_enable);

   // ****************************************
   // gauge operation control
   // ****************************************
   // whole byte is writable; reset leaves gauge off in active mode
   always_ff @(posedge clk) begin
      if (rst) begin
         gauge_mode_reg <= gauge_mode_s'(`GAUGE_MODE_RESET);
      end else if (wr_mode) begin
         gauge_mode_reg <= gauge_mode_s'(reg_wr_data);
      end
   end

   // ****************************************
   // step-down configuration and output voltage
   // ****************************************
   // factory settings come in as parameters so each trim can differ
   always_ff @(posedge clk) begin
      if (rst) begin
         stepdown_cfg_reg.soft_start <= SOFT_START_DEFAULT;
         stepdown_cfg_reg.stepdown_peak_limit <= `PEAK_LIMIT_RESET;
         stepdown_cfg_reg.forced_pulse_width_modulation <= FORCED_PULSE_WIDTH_MODULATION_DEFAULT;
         stepdown_cfg_reg.stepdown_pulse_stop <= `PULSE_STOP_RESET;
         stepdown_cfg_reg.stepdown_output_discharge <= DISCHARGE_DEFAULT;
         stepdown_cfg_reg.stepdown_enable <= OUTPUT_ON_DEFAULT;
      end else if (wr_cfg) begin
         stepdown_cfg_reg <= stepdown_cfg_s'(reg_wr_data);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stepdown_vout_reg.stepdown_switch_delay <= `SWITCH_DELAY_RESET;
         stepdown_vout_reg.stepdown_voltage_code <= VOLTAGE_CODE_DEFAULT;
      end else if (wr_vout) begin
         stepdown_vout_reg <= stepdown_vout_s'(reg_wr_data);
      end
   end

   // ****************************************
   // readback snapshots
   // ****************************************
   logic [12:0] voltage_snap_reg;
   logic [11:0] accum_snap_reg;

   // held copies keep high and low bytes coherent between two host reads
   always_ff @(posedge clk) begin
      if (rst) voltage_snap_reg <= `VOLTAGE_RESET;
      else if (snapshot) voltage_snap_reg <= vbat_measured;
   end

   always_ff @(posedge clk) begin
      if (rst) charge_level_reg <= `LEVEL_RESET;
      else if (snapshot) charge_level_reg <= charge_level_measured;
   end

   always_ff @(posedge clk) begin
      if (rst) accum_snap_reg <= `ACCUM_RESET;
      else if (snapshot) accum_snap_reg <= accum_live;
   end

   // ****************************************
   // read path
   // ****************************************
   logic [7:0] rd_mux;
   // write-only refresh bit and reserved bits read as zero
   always_comb begin
      unique case (reg_addr)
         `ADDR_ACCUM_HIGH: rd_mux = accum_snap_reg[11:4];
         `ADDR_ACCUM_LOW: rd_mux = {accum_snap_reg[3:0], `ACCUM_LOW_PAD};
         `ADDR_VOLTAGE_HIGH: rd_mux = voltage_snap_reg[12:5];
         `ADDR_VOLTAGE_LOW: rd_mux = {voltage_snap_reg[4:0], `VOLTAGE_LOW_PAD};
         `ADDR_GAUGE_MODE: rd_mux = gauge_mode_reg;
         `ADDR_REFRESH: rd_mux = `REFRESH_READ;
         `ADDR_STEPDOWN_CFG: rd_mux = stepdown_cfg_reg;
         `ADDR_STEPDOWN_VOUT: rd_mux = stepdown_vout_reg;
         default: rd_mux = `UNMAPPED_READ;
      endcase
   end

   // read data holds until the next read
   always_ff @(posedge clk) begin
      if (rst) reg_rd_data_reg <= `UNMAPPED_READ;
      else if (reg_rd_en) reg_rd_data_reg <= rd_mux;
   end

   always_ff @(posedge clk) begin
      if (rst) reg_rd_valid_reg <= 1'b0;
      else reg_rd_valid_reg <= reg_rd_en;
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_read_of(logic [7:0] a);
      reg_rd_en && reg_addr == a;
   endsequence

   a_reset_mode: assert property ($fell(rst) |-> gauge_mode_reg == `GAUGE_MODE_RESET)
      else $error("gauge mode reset value wrong");
   a_mode_write: assert property (wr_mode |=> gauge_mode_reg == $past(reg_wr_data))
      else $error("gauge mode write lost");
   a_cfg_write: assert property (wr_cfg |=> stepdown_cfg_reg == $past(reg_wr_data))
      else $error("step-down configuration write lost");
   a_vout_write: assert property (wr_vout ##1 !wr_vout |=>
      stepdown_vout_reg == $past(reg_wr_data, 2))
      else $error("output voltage write not held");
   a_accum_high: assert property (s_read_of(`ADDR_ACCUM_HIGH)
      |=> reg_rd_valid_reg && reg_rd_data_reg == $past(accum_snap_reg[11:4]))
      else $error("accumulator high byte wrong");
   a_accum_low: assert property (s_read_of(`ADDR_ACCUM_LOW)
      |=> reg_rd_data_reg == {$past(accum_snap_reg[3:0]), 4'h0})
      else $error("accumulator low byte wrong");
   a_volt_high: assert property (s_read_of(`ADDR_VOLTAGE_HIGH)
      |=> reg_rd_data_reg == $past(voltage_snap_reg[12:5]))
      else $error("voltage high byte wrong");
   a_volt_low: assert property (s_read_of(`ADDR_VOLTAGE_LOW)
      |=> reg_rd_data_reg[2:0] == 3'h0 && reg_rd_data_reg[7:3] == $past(voltage_snap_reg[4:0]))
      else $error("voltage low byte wrong");
   a_snap_hold: assert property (!snapshot |=> $stable(voltage_snap_reg)
      && $stable(accum_snap_reg))
      else $error("readback moved without an update event");
   a_refresh_load: assert property (refresh_pulse |=> voltage_snap_reg == $past(vbat_measured)
      && charge_level_reg == $past(charge_level_measured))
      else $error("refresh did not load readbacks");

   // ****************************************
   // reset values, read strobe and holds
   // ****************************************
   // first edge after rst falls; factory trims included
   sequence s_reset_done;
      $fell(rst);
   endsequence

   // enabled core update, the other snapshot source
   sequence s_update_on;
      gauge_update && gauge_mode_reg.gauge_enable;
   endsequence

   a_reset_cfg: assert property (s_reset_done |-> stepdown_cfg_reg == {
      SOFT_START_DEFAULT, `PEAK_LIMIT_RESET, FORCED_PULSE_WIDTH_MODULATION_DEFAULT, `PULSE_STOP_RESET,
      DISCHARGE_DEFAULT, OUTPUT_ON_DEFAULT})
      else $error("step-down configuration reset value wrong");
   a_reset_vout: assert property (s_reset_done |->
      stepdown_vout_reg == {`SWITCH_DELAY_RESET, VOLTAGE_CODE_DEFAULT})
      else $error("output voltage reset value wrong");
   a_reset_snap: assert property (s_reset_done |->
      voltage_snap_reg == `VOLTAGE_RESET && accum_snap_reg == `ACCUM_RESET)
      else $error("snapshots not cleared by reset");

   // valid is a one-cycle echo of the read strobe
   a_read_valid: assert property (reg_rd_en |=> reg_rd_valid_reg)
      else $error("read answered without valid");
   a_valid_pulse: assert property (!reg_rd_en |=> !reg_rd_valid_reg)
      else $error("valid raised without a read");
   a_data_hold: assert property (!reg_rd_en |=> $stable(reg_rd_data_reg))
      else $error("read data moved without a read");
   a_refresh_read: assert property (s_read_of(`ADDR_REFRESH)
      |=> reg_rd_data_reg == `REFRESH_READ)
      else $error("refresh register did not read zero");
   a_mode_read: assert property (s_read_of(`ADDR_GAUGE_MODE)
      |=> reg_rd_data_reg == $past(gauge_mode_reg))
      else $error("gauge mode read wrong");

   // core updates count only while the gauge is enabled
   a_update_load: assert property (s_update_on |=>
      voltage_snap_reg == $past(vbat_measured) && accum_snap_reg == $past(accum_live))
      else $error("enabled update did not load readbacks");
   a_update_gated: assert property (gauge_update && !gauge_mode_reg.gauge_enable
      && !refresh_pulse |=> $stable(voltage_snap_reg) && $stable(charge_level_reg))
      else $error("disabled gauge update moved readbacks");
   a_refresh_accum: assert property (refresh_pulse |=> accum_snap_reg == $past(accum_live))
      else $error("refresh did not load the count");
   a_level_hold: assert property (!snapshot |=> $stable(charge_level_reg))
      else $error("charge level moved without an update event");

   // accumulator and capacity
   a_accum_step: assert property (charge_step |=> accum_live == $past(accum_live) + 12'h001)
      else $error("count did not step");
   a_overflow_pulse: assert property (accum_overflow_reg |=> !accum_overflow_reg)
      else $error("overflow stood too long");
   a_cap_load: assert property (cap_load |=> capacity_reg == $past(cap_setting))
      else $error("capacity load lost");

   // control registers move only on their own write
   a_mode_hold: assert property (!wr_mode |=> $stable(gauge_mode_reg))
      else $error("gauge mode moved without a write");
   a_cfg_hold: assert property (!wr_cfg |=> $stable(stepdown_cfg_reg))
      else $error("step-down configuration moved without a write");
   a_vout_hold: assert property (!wr_vout |=> $stable(stepdown_vout_reg))
      else $error("output voltage moved without a write");
endmodule : fuel_gauge_buck_ctrl_regs

// file: dv/host_model.sv
// host model of the serial register port: single-cycle write and read strobes
// assumes the bank answers a read exactly one cycle after the strobe edge
`timescale 1ns/10ps
`include "fuel_gauge_buck_defs.svh"
module host_model (
   // clock
   input wire logic clk,
   // register port towards the bank
   output logic [7:0] reg_addr,
   output logic reg_wr_en,
   output logic [7:0] reg_wr_data,
   output logic reg_rd_en,
   input wire logic [7:0] reg_rd_data_reg,
   input wire logic reg_rd_valid_reg
);
   // ****************************************
   // bus cycles
   // ****************************************
   // idle: released address and data show the inverse, never a stale match
   initial begin
      reg_addr = 8'hFF;
      reg_wr_en = 1'b0;
      reg_wr_data = 8'hFF;
      reg_rd_en = 1'b0;
   end

   // one write strobe, held for exactly one sampling edge
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wr_data <= d;
      reg_wr_en <= 1'b1;
      @(posedge clk);
      reg_wr_en <= 1'b0;
      reg_addr <= ~a;
      reg_wr_data <= ~d;
   endtask : write_reg

   // one read strobe; answer taken once the answering edge has landed
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(posedge clk);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge clk);
      reg_rd_en <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rd_data_reg;
      ok = reg_rd_valid_reg;
   endtask : read_reg

   // refresh: one then zero on the refresh bit, sampled two edges apart with one idle edge between
   task automatic refresh();
      write_reg(`ADDR_REFRESH, 8'h80);
      write_reg(`ADDR_REFRESH, 8'h00);
   endtask : refresh

   // charge cycles as software sees them: whole count over one hundred
   function automatic int cycles_of(input logic [11:0] cnt);
      return int'(cnt) / 100;
   endfunction : cycles_of
endmodule : host_model

// file: dv/fuel_gauge_buck_ctrl_regs_test.sv
// self-checking bench for the gauge and step-down register bank
// assumes factory defaults left at zero and a 25 MHz clock
`timescale 1ns/10ps
`include "fuel_gauge_buck_defs.svh"
module fuel_gauge_buck_ctrl_regs_test;
   import fuel_gauge_buck_pkg::*;
   logic clk, rst;
   logic [7:0] reg_addr, reg_wr_data, reg_rd_data_reg;
   logic reg_wr_en, reg_rd_en, reg_rd_valid_reg;
   logic [12:0] vbat_measured;
   logic [6:0] charge_level_measured, charge_level_reg;
   logic gauge_update, charge_step, aging_enable, cap_load, accum_overflow_reg;
   logic [1:0] aging_code;
   logic [7:0] cap_setting, capacity_reg;
   gauge_mode_s gauge_mode_reg;
   stepdown_cfg_s stepdown_cfg_reg;
   stepdown_vout_s stepdown_vout_reg;
   int fail_count = 0;
   int checks_done = 0;
   logic [12:0] vb;

   fuel_gauge_buck_ctrl_regs u_fuel_gauge_buck_ctrl_regs (.clk(clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
      .reg_rd_en(reg_rd_en), .reg_rd_data_reg(reg_rd_data_reg),
      .reg_rd_valid_reg(reg_rd_valid_reg), .vbat_measured(vbat_measured),
      .charge_level_measured(charge_level_measured), .gauge_update(gauge_update),
      .charge_step(charge_step), .aging_enable(aging_enable), .aging_code(aging_code),
      .cap_load(cap_load), .cap_setting(cap_setting), .gauge_mode_reg(gauge_mode_reg),
      .charge_level_reg(charge_level_reg), .capacity_reg(capacity_reg),
      .accum_overflow_reg(accum_overflow_reg), .stepdown_cfg_reg(stepdown_cfg_reg),
      .stepdown_vout_reg(stepdown_vout_reg));
   host_model u_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
      .reg_rd_data_reg(reg_rd_data_reg), .reg_rd_valid_reg(reg_rd_valid_reg));

   // ****************************************
   // helpers
   // ****************************************
   // 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // read through the host and judge both valid and data
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
      logic [7:0] d;
      logic ok;
      u_host_model.read_reg(a, d, ok);
      chk({what, " valid"}, 8'h01, {7'h00, ok});
      chk(what, exp, d);
   endtask : rd_chk

   task automatic step_n(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         charge_step <= 1'b1;
      end
      @(posedge clk);
      charge_step <= 1'b0;
   endtask : step_n

   task automatic pulse_update();
      @(posedge clk);
      gauge_update <= 1'b1;
      @(posedge clk);
      gauge_update <= 1'b0;
   endtask : pulse_update

   // readbacks of a 12-bit count and a 13-bit voltage snapshot
   task automatic snap_chk(input logic [11:0] c, input logic [12:0] v);
      rd_chk(`ADDR_ACCUM_HIGH, c[11:4], "accum high");
      rd_chk(`ADDR_ACCUM_LOW, {c[3:0], 4'h0}, "accum low");
      rd_chk(`ADDR_VOLTAGE_HIGH, v[12:5], "volt high");
      rd_chk(`ADDR_VOLTAGE_LOW, {v[4:0], 3'h0}, "volt low");
   endtask : snap_chk

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset_values();
      rd_chk(`ADDR_GAUGE_MODE, {2'b01, 2'b01, 2'b00, 1'b0, 1'b0}, "mode");
      rd_chk(`ADDR_STEPDOWN_CFG, {2'b00, 2'b11, 4'h0}, "cfg");
      rd_chk(`ADDR_STEPDOWN_VOUT, 8'h00, "vout");
      snap_chk(12'h000, 13'h0000);
      rd_chk(`ADDR_REFRESH, 8'h00, "refresh read");
      rd_chk(8'h40, 8'h00, "unmapped");
      $display("test reset_values done");
   endtask : t_reset_values

   // four byte patterns (00, 5A, A5, FF) on every field, through registers and ports
   task automatic t_write_read();
      logic [7:0] vals [4] = '{8'h00, 8'h5A, 8'hA5, 8'hFF};
      foreach (vals[i]) begin
         u_host_model.write_reg(`ADDR_GAUGE_MODE, vals[i]);
         u_host_model.write_reg(`ADDR_STEPDOWN_CFG, vals[i]);
         u_host_model.write_reg(`ADDR_STEPDOWN_VOUT, vals[i]);
         rd_chk(`ADDR_GAUGE_MODE, vals[i], "mode rw");
         rd_chk(`ADDR_STEPDOWN_CFG, vals[i], "cfg rw");
         rd_chk(`ADDR_STEPDOWN_VOUT, vals[i], "vout rw");
         chk("mode port", vals[i], gauge_mode_reg);
         chk("cfg port", vals[i], stepdown_cfg_reg);
         chk("vout port", vals[i], stepdown_vout_reg);
      end
      u_host_model.write_reg(`ADDR_ACCUM_HIGH, 8'hFF);
      rd_chk(`ADDR_ACCUM_HIGH, 8'h00, "accum read only");
      u_host_model.write_reg(`ADDR_GAUGE_MODE, 8'h00);
      $display("test write_read done");
   endtask : t_write_read

   task automatic t_refresh();
      logic [7:0] hi;
      logic [7:0] lo;
      logic ok;
      vbat_measured <= 13'h1A5B;
      charge_level_measured <= 7'h2D;
      step_n(12'h123);
      snap_chk(12'h000, 13'h0000);
      u_host_model.write_reg(`ADDR_REFRESH, 8'h00);
      repeat (3) @(posedge clk);
      rd_chk(`ADDR_VOLTAGE_HIGH, 8'h00, "lone zero");
      u_host_model.refresh();
      repeat (2) @(posedge clk);
      #1;
      chk("level", {1'b0, 7'h2D}, {1'b0, charge_level_reg});
      snap_chk(12'h123, 13'h1A5B);
      u_host_model.read_reg(`ADDR_ACCUM_HIGH, hi, ok);
      u_host_model.read_reg(`ADDR_ACCUM_LOW, lo, ok);
      chk("charge cycles", 8'h02, 8'(u_host_model.cycles_of({hi, lo[7:4]})));
      $display("test refresh done");
   endtask : t_refresh

   // update pulses only snapshot while the gauge is enabled
   task automatic t_gauge_update();
      vbat_measured <= 13'h0ACE;
      pulse_update();
      rd_chk(`ADDR_VOLTAGE_HIGH, vb[12:5], "update gated");
      u_host_model.write_reg(`ADDR_GAUGE_MODE, 8'h01);
      pulse_update();
      snap_chk(12'h123, 13'h0ACE);
      $display("test gauge_update done");
   endtask : t_gauge_update

   // every aging code, each from a fresh capacity of 0x80
   task automatic t_overflow();
      logic [7:0] cap_exp [4] = '{8'h7F, 8'h7E, 8'h7C, 8'h78};
      step_n(4096 - 12'h123 - 1);
      foreach (cap_exp[i]) begin
         @(posedge clk);
         cap_setting <= 8'h80;
         cap_load <= 1'b1;
         aging_enable <= 1'b1;
         aging_code <= 2'(i);
         @(posedge clk);
         cap_load <= 1'b0;
         if (i > 0) step_n(4095);
         step_n(1);
         #1;
         chk("overflow", 8'h01, {7'h00, accum_overflow_reg});
         @(posedge clk);
         #1;
         chk("overflow end", 8'h00, {7'h00, accum_overflow_reg});
         chk("capacity", cap_exp[i], capacity_reg);
      end
      u_host_model.refresh();
      snap_chk(12'h000, 13'h0ACE);
      $display("test overflow done");
   endtask : t_overflow

   // ****************************************
   // run control
   // ****************************************
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   // about 16500 cycles expected; allow ample margin
   initial begin
      #(40 * 40000);
      fail_count++;
      $display("[ERR] watchdog expected done seen hang");
      report_and_stop();
   end

   initial begin
      rst = 1'b1;
      vbat_measured = 13'h0000;
      charge_level_measured = 7'h00;
      gauge_update = 1'b0;
      charge_step = 1'b0;
      aging_enable = 1'b0;
      aging_code = 2'b00;
      cap_load = 1'b0;
      cap_setting = 8'h00;
      vb = 13'h1A5B;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset_values();
      t_write_read();
      t_refresh();
      t_gauge_update();
      t_overflow();
      report_and_stop();
   end
endmodule : fuel_gauge_buck_ctrl_regs_test
